// [hw/cpms_pkg.sv]
package cpms_pkg;
  localparam int CPMS_SYNC_STAGES = 2;
  localparam int CPMS_ADDR_BITS = 3;
  localparam int CPMS_ADDR_BIT0_POS = 0;
  localparam int CPMS_ADDR_BIT1_POS = 1;
  localparam int CPMS_ADDR_BIT2_POS = 2;
  localparam logic CPMS_RST_SW_MODE = 1'b0;
  localparam logic CPMS_RST_SPI_MODE = 1'b0;
  localparam logic [2:0] CPMS_RST_ADDR = 3'h0;
  localparam logic CPMS_RST_PIN_LEVEL = 1'b1;
  localparam logic CPMS_RST_CS_LEVEL = 1'b1;
  localparam logic CPMS_RST_CLK_LEVEL = 1'b1;
  localparam logic CPMS_RST_DATA_LEVEL = 1'b1;

  typedef enum logic [1:0] {
    CPMS_ST_RESET,
    CPMS_ST_STRAP,
    CPMS_ST_RUN
  } cpms_state_e;
endpackage : cpms_pkg

// [hw/cpms_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module cpms_sync
  import cpms_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } cpms_sync_s;

  cpms_sync_s st_q;
  cpms_sync_s st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d.meta = i_async;
    st_d.sync = st_q.meta;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      st_q.meta <= RESET_VAL;
      st_q.sync <= RESET_VAL;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_sync = st_q.sync;
endmodule : cpms_sync
`default_nettype wire

// [hw/cpms_top.sv]
// Summary of operation
// - Pulled-up audio output pin selects software mode
// - Two-wire data line is open-drain, never driven high
// - Four-wire read data leaves on serial read line
// - Host clock edges shift bits in and out
// - Select-pin falling edge enters four-wire mode permanently
// - Two-wire mode uses address pins as address
// - Four-wire traffic ignored while select is high
// - Four-wire write data enters on address-one pin
// - Reset low holds everything at reset, low power
`timescale 1ns/1ps
`default_nettype none
module cpms_top
  import cpms_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_serial_audio_out_pin,
  input wire logic i_slave_addr_bit_zero,
  input wire logic i_slave_addr_bit_one,
  input wire logic i_slave_addr_bit_two,
  input wire logic i_ctrl_shift_clock,
  input wire logic i_ctrl_data_in,
  input wire logic i_core_read_bit,
  input wire logic i_core_sda_pull_low,
  output logic o_ctrl_data_out,
  output logic o_ctrl_data_oe_b,
  output logic o_sw_mode,
  output logic o_spi_mode,
  output logic [CPMS_ADDR_BITS-1:0] o_slave_addr,
  output logic o_port_enable,
  output logic o_shift_in_pulse,
  output logic o_shift_out_pulse,
  output logic o_serial_write_bit,
  output logic o_low_power
);
  typedef struct packed {
    cpms_state_e state;
    logic [1:0] settle;
    logic sw_mode;
    logic spi_mode;
    logic [CPMS_ADDR_BITS-1:0] addr;
    logic cs_prev;
    logic clk_prev;
    logic port_en;
    logic shift_in;
    logic shift_out;
    logic write_bit;
    logic data_out;
    logic data_oe_b;
    logic low_power;
  } cpms_top_s;

  cpms_top_s st_q;
  cpms_top_s st_d;
  logic [4:0] pins_s;
  logic serial_audio_out_pin_s;
  logic cs_s;
  logic din_s;
  logic a2_s;
  logic clk_s;
  logic clk_rise;
  logic clk_fall;
  logic cs_fall;

  // The sync module is fixed at two flops and the strap wait counts on
  // that depth; the address width is fixed by the three strap pins
  if (CPMS_SYNC_STAGES != 2) begin : g_bad_sync_depth
    $error("synchroniser depth must be two");
  end
  if (CPMS_ADDR_BITS != 3) begin : g_bad_addr_width
    $error("strap address must be three bits wide");
  end

  // Both edge finders compare against the registered copy, so a pin
  // that sits still never yields a pulse however long it stays
  function automatic logic f_rose(input logic prev, input logic now);
    return !prev && now;
  endfunction : f_rose

  function automatic logic f_fell(input logic prev, input logic now);
    return prev && !now;
  endfunction : f_fell

  // The five strap, select and clock pins are foreign to the core clock, so all pass two flops
  cpms_sync #(
    .WIDTH(5),
    .RESET_VAL({
      CPMS_RST_PIN_LEVEL,
      CPMS_RST_CS_LEVEL,
      CPMS_RST_DATA_LEVEL,
      CPMS_RST_PIN_LEVEL,
      CPMS_RST_CLK_LEVEL
    })
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_async({
      i_serial_audio_out_pin,
      i_slave_addr_bit_zero,
      i_slave_addr_bit_one,
      i_slave_addr_bit_two,
      i_ctrl_shift_clock
    }),
    .o_sync(pins_s)
  );

  assign serial_audio_out_pin_s = pins_s[4];
  assign cs_s = pins_s[3];
  assign din_s = pins_s[2];
  assign a2_s = pins_s[1];
  assign clk_s = pins_s[0];

  assign clk_rise = f_rose(st_q.clk_prev, clk_s);
  assign clk_fall = f_fell(st_q.clk_prev, clk_s);
  assign cs_fall = f_fell(st_q.cs_prev, cs_s);

  always_comb begin
    st_d = st_q;
    st_d.shift_in = 1'b0;
    st_d.shift_out = 1'b0;
    // Low power is only shown while reset is held
    st_d.low_power = 1'b0;
    st_d.cs_prev = cs_s;
    st_d.clk_prev = clk_s;
    case (st_q.state)
      CPMS_ST_RESET: begin
        // Waits for the synchronisers to carry real pin levels, since
        // latching their reset value would fake a strap and a select edge
        if (st_q.settle == 2'(CPMS_SYNC_STAGES - 1)) begin
          st_d.state = CPMS_ST_STRAP;
        end else begin
          st_d.settle = st_q.settle + 2'h1;
        end
      end
      CPMS_ST_STRAP: begin
        // Read once; later activity on these pins is traffic, not strapping
        st_d.sw_mode = serial_audio_out_pin_s;
        st_d.addr[CPMS_ADDR_BIT0_POS] = cs_s;
        st_d.addr[CPMS_ADDR_BIT1_POS] = din_s;
        st_d.addr[CPMS_ADDR_BIT2_POS] = a2_s;
        st_d.state = CPMS_ST_RUN;
      end
      CPMS_ST_RUN: begin
        if (st_q.sw_mode) begin
          // Sticky: only reset leaves four-wire mode
          if (cs_fall) begin
            st_d.spi_mode = 1'b1;
          end
          if (st_d.spi_mode) begin
            // In four-wire mode the select pin gates the port
            st_d.port_en = !cs_s;
          end else begin
            st_d.port_en = 1'b1;
          end
          if (st_d.port_en) begin
            st_d.shift_in = clk_rise;
            st_d.shift_out = clk_fall;
          end
          if (st_d.spi_mode) begin
            if (clk_rise && st_d.port_en) begin
              st_d.write_bit = din_s;
            end
            st_d.data_out = i_core_read_bit;
            st_d.data_oe_b = !st_d.port_en;
          end else begin
            // Two-wire data arrives already synchronised by the pad logic
            st_d.write_bit = i_ctrl_data_in;
            // Only ever pulls low; the board pull-up supplies the high
            st_d.data_out = 1'b0;
            st_d.data_oe_b = !i_core_sda_pull_low;
          end
        end else begin
          // Hardware mode: the port stays off and the data pin is released
          st_d.port_en = 1'b0;
          st_d.data_oe_b = 1'b1;
        end
      end
      default: begin
        st_d.state = CPMS_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      st_q.state <= CPMS_ST_RESET;
      st_q.settle <= 2'h0;
      st_q.sw_mode <= CPMS_RST_SW_MODE;
      st_q.spi_mode <= CPMS_RST_SPI_MODE;
      st_q.addr <= CPMS_RST_ADDR;
      st_q.cs_prev <= CPMS_RST_CS_LEVEL;
      st_q.clk_prev <= CPMS_RST_CLK_LEVEL;
      st_q.port_en <= 1'b0;
      st_q.shift_in <= 1'b0;
      st_q.shift_out <= 1'b0;
      st_q.write_bit <= 1'b0;
      st_q.data_out <= 1'b0;
      st_q.data_oe_b <= 1'b1;
      st_q.low_power <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_ctrl_data_out = st_q.data_out;
  assign o_ctrl_data_oe_b = st_q.data_oe_b;
  assign o_sw_mode = st_q.sw_mode;
  assign o_spi_mode = st_q.spi_mode;
  assign o_slave_addr = st_q.addr;
  assign o_port_enable = st_q.port_en;
  assign o_shift_in_pulse = st_q.shift_in;
  assign o_shift_out_pulse = st_q.shift_out;
  assign o_serial_write_bit = st_q.write_bit;
  assign o_low_power = st_q.low_power;
endmodule : cpms_top
`default_nettype wire

// [verif/cpms_props.sv]
`timescale 1ns/1ps
`default_nettype none
module cpms_props
  import cpms_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_slave_addr_bit_zero,
  input wire logic i_ctrl_shift_clock,
  input wire logic i_core_read_bit,
  input wire logic o_ctrl_data_out,
  input wire logic o_ctrl_data_oe_b,
  input wire logic o_sw_mode,
  input wire logic o_spi_mode,
  input wire logic [CPMS_ADDR_BITS-1:0] o_slave_addr,
  input wire logic o_port_enable,
  input wire logic o_shift_in_pulse,
  input wire logic o_shift_out_pulse,
  input wire logic o_low_power
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  sequence sel_fall;
    o_sw_mode && $fell(i_slave_addr_bit_zero);
  endsequence
  // Six idle cycles cover the three-cycle edge pipeline
  sequence sel_idle;
    i_slave_addr_bit_zero [*6] ##0 o_spi_mode;
  endsequence
  a_reset_holds: assert property (disable iff (1'b0) !i_rst_b |=> o_low_power && o_ctrl_data_oe_b)
    else $error("reset state lost");
  a_power_up: assert property ($rose(i_rst_b) |-> ##[1:2] !o_low_power)
    else $error("low power stuck");
  a_sw_gate: assert property (o_port_enable |-> o_sw_mode)
    else $error("port without strap");
  a_od_low: assert property (!o_spi_mode && !o_ctrl_data_oe_b |-> !o_ctrl_data_out)
    else $error("data line driven high");
  a_read_follow: assert property (o_spi_mode |-> o_ctrl_data_out == $past(i_core_read_bit))
    else $error("read bit lost");
  a_shift_in: assert property ($rose(i_ctrl_shift_clock) && o_port_enable && !o_spi_mode
    |-> ##[1:5] o_shift_in_pulse)
    else $error("no shift pulse");
  a_spi_entry: assert property (sel_fall |-> ##[1:4] o_spi_mode)
    else $error("no four-wire entry");
  a_sel_ignore: assert property (sel_idle |-> !o_shift_in_pulse && !o_shift_out_pulse)
    else $error("pulse while deselected");
  a_strap_hold: assert property (o_port_enable |=> $stable(o_slave_addr) && $stable(o_sw_mode))
    else $error("strap changed");
endmodule : cpms_props
`default_nettype wire

// [verif/cpms_host.sv]
`timescale 1ns/1ps
`default_nettype none
module cpms_host (
  input wire logic i_core_clk,
  output logic o_sck,
  output logic o_sel_b,
  output logic o_din
);
  initial begin
    o_sck = 1'b1;
    o_sel_b = 1'b1;
    o_din = 1'b1;
  end
  task automatic pins(input logic a0, input logic a1);
    @(negedge i_core_clk);
    o_sel_b = a0;
    o_din = a1;
  endtask : pins
  // Clock stands high between frames, 160 ns period inside them
  task automatic frame(input logic [7:0] b, input logic sel);
    @(negedge i_core_clk);
    o_sel_b = ~sel;
    for (int i = 7; i >= 0; i--) begin
      repeat (4) @(negedge i_core_clk);
      o_sck = 1'b0;
      o_din = b[i];
      repeat (4) @(negedge i_core_clk);
      o_sck = 1'b1;
    end
    repeat (4) @(negedge i_core_clk);
    o_sel_b = 1'b1;
    o_din = ~b[0];
  endtask : frame
endmodule : cpms_host
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cpms_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, sw = 1'b1, a2 = 1'b1, rd = 1'b0, pull = 1'b0;
  logic sck, sel_b, din, dout, oe_b, swm, spim, pen, sin, sout, wbit, lp;
  logic [2:0] addr;
  logic [7:0] got = 8'h00;
  int fail_count = 0, cmp_count = 0, n_in = 0, n_out = 0, cyc = 0;
  always #10 clk = ~clk;
  cpms_host host (.i_core_clk(clk), .o_sck(sck), .o_sel_b(sel_b), .o_din(din));
  cpms_top dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_serial_audio_out_pin(sw),
    .i_slave_addr_bit_zero(sel_b), .i_slave_addr_bit_one(din), .i_slave_addr_bit_two(a2),
    .i_ctrl_shift_clock(sck), .i_ctrl_data_in(din), .i_core_read_bit(rd),
    .i_core_sda_pull_low(pull), .o_ctrl_data_out(dout), .o_ctrl_data_oe_b(oe_b),
    .o_sw_mode(swm), .o_spi_mode(spim), .o_slave_addr(addr), .o_port_enable(pen),
    .o_shift_in_pulse(sin), .o_shift_out_pulse(sout), .o_serial_write_bit(wbit),
    .o_low_power(lp));
  // Outputs change on the rising edge, so they are read half a cycle later
  always @(negedge clk) begin
    cyc++;
    if (sout) n_out++;
    if (sin) begin
      n_in++;
      got = {got[6:0], wbit};
    end
    if (cyc == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic rst(input logic v);
    @(negedge clk);
    rst_b = 1'b0;
    sw = v;
    repeat (6) @(negedge clk);
    chk({lp, oe_b}, 9'h003);
    rst_b = 1'b1;
    repeat (6) @(negedge clk);
  endtask : rst
  task automatic t_two();
    host.pins(1'b1, 1'b0);
    rst(1'b1);
    chk({swm, pen, addr}, 9'h01D);
    a2 = 1'b0;
    host.pins(1'b1, 1'b1);
    pull = 1'b1;
    repeat (4) @(negedge clk);
    chk({addr, oe_b, dout}, 5'h14);
    pull = 1'b0;
    repeat (4) @(negedge clk);
    chk(oe_b, 1'b1);
    n_in = 0;
    n_out = 0;
    host.frame(8'h3C, 1'b0);
    repeat (6) @(negedge clk);
    chk({spim, n_in[3:0], n_out[3:0]}, 9'h088);
    chk(got, 9'h03C);
    $display("two-wire test done");
  endtask : t_two
  task automatic t_four();
    n_in = 0;
    n_out = 0;
    host.frame(8'hA5, 1'b1);
    repeat (6) @(negedge clk);
    chk({spim, got}, 9'h1A5);
    chk({spim, n_in[3:0], n_out[3:0]}, 9'h188);
    rd = 1'b1;
    repeat (2) @(negedge clk);
    chk({dout, oe_b}, 9'h003);
    n_in = 0;
    n_out = 0;
    host.frame(8'hFF, 1'b0);
    repeat (6) @(negedge clk);
    chk({n_in[3:0], n_out[3:0]}, 9'h000);
    $display("four-wire test done");
  endtask : t_four
  task automatic t_hw();
    rst(1'b0);
    chk({swm, addr, oe_b}, 9'h003);
    n_in = 0;
    host.frame(8'h55, 1'b1);
    repeat (6) @(negedge clk);
    chk({pen, spim, n_in[5:0]}, 8'h00);
    $display("hardware mode test done");
  endtask : t_hw
  initial begin
    t_two();
    t_four();
    t_hw();
    finish_test();
  end
endmodule : tb
bind cpms_top cpms_props u_props (
  .i_core_clk(i_core_clk),
  .i_rst_b(i_rst_b),
  .i_slave_addr_bit_zero(i_slave_addr_bit_zero),
  .i_ctrl_shift_clock(i_ctrl_shift_clock),
  .i_core_read_bit(i_core_read_bit),
  .o_ctrl_data_out(o_ctrl_data_out),
  .o_ctrl_data_oe_b(o_ctrl_data_oe_b),
  .o_sw_mode(o_sw_mode),
  .o_spi_mode(o_spi_mode),
  .o_slave_addr(o_slave_addr),
  .o_port_enable(o_port_enable),
  .o_shift_in_pulse(o_shift_in_pulse),
  .o_shift_out_pulse(o_shift_out_pulse),
  .o_low_power(o_low_power)
);
`default_nettype wire
